// ### rtl/lts_pkg.sv
// Constants and types for the local time shift and minute alignment block
//==============================================================
// Overview of operation
// - Shift disabled by default; then clock keeps standard time only.
// - Shift enabled: add an hour at start point, remove one at end.
// - Start date is month, week selector (1-4 or last), weekday; March/last/Sunday.
// - Start hour accepted only within 1..6, default 2.
// - End point uses same month, week, weekday and 1..6 hour encoding.
// - Start and end points both default to March/last/Sunday at hour 2.
// - Sync source is none (default) or one of twelve digital inputs.
// - Pulse edge rounds clock to nearest whole minute, seconds zeroed.
// - Pulse is taken after the selected input's debounce filter.
package lts_pkg;
  //==============================================================
  // Timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned TICK_CYCLES     = CLK_HZ;
  //==============================================================
  // Register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_START  = 8'h04;
  localparam logic [7:0] ADDR_END    = 8'h08;
  localparam logic [7:0] ADDR_TIME   = 8'h0c;
  localparam logic [7:0] ADDR_DATE   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  //==============================================================
  // Field positions
  localparam int CTRL_EN   = 0;
  localparam int CTRL_SRC  = 4;
  localparam int CTRL_CTRY = 8;
  localparam int PT_MON    = 0;
  localparam int PT_WEEK   = 4;
  localparam int PT_WDAY   = 8;
  localparam int PT_HOUR   = 12;
  localparam int TM_SEC    = 0;
  localparam int TM_MIN    = 8;
  localparam int TM_HOUR   = 16;
  localparam int DT_MDAY   = 0;
  localparam int DT_MON    = 8;
  localparam int DT_WDAY   = 16;
  localparam int DT_YEAR   = 24;
  //==============================================================
  // Encodings and reset values
  localparam logic [3:0] NUM_INPUTS = 4'hc;
  localparam logic [2:0] WEEK_LAST  = 3'h0;
  localparam logic [2:0] HOUR_MIN   = 3'h1;
  localparam logic [2:0] HOUR_MAX   = 3'h6;
  localparam logic [3:0] RST_PT_MON  = 4'h3;
  localparam logic [2:0] RST_PT_WEEK = 3'h0;
  localparam logic [2:0] RST_PT_WDAY = 3'h7;
  localparam logic [2:0] RST_PT_HOUR = 3'h2;
  localparam logic [3:0] RST_SRC     = 4'h0;
  localparam logic [7:0] RST_CTRY    = 8'h00;
  localparam logic [4:0] RST_MDAY    = 5'h01;
  localparam logic [3:0] RST_MON     = 4'h1;
  localparam logic [2:0] RST_WDAY    = 3'h6;
  localparam logic [6:0] RST_YEAR    = 7'h00;

  typedef struct packed {
    logic [3:0] month;
    logic [2:0] week;
    logic [2:0] wday;
    logic [2:0] hour;
  } lts_point_s;

  localparam lts_point_s RST_POINT = '{RST_PT_MON, RST_PT_WEEK,
                                       RST_PT_WDAY, RST_PT_HOUR};
endpackage

// ### rtl/lts_sync_if.sv
// Carrier between the time core and the minute pulse front end
`timescale 1ns/100ps
`default_nettype none
interface lts_sync_if;
  logic [3:0] source;
  logic       minutePulse;
  modport ctrl (output source, input minutePulse);
  modport sync (input source, output minutePulse);
endinterface
`default_nettype wire

// ### rtl/lts_minute_sync.sv
// Minute pulse front end: synchroniser, debounce and edge detect
`timescale 1ns/100ps
`default_nettype none
module lts_minute_sync #(
  parameter int unsigned DEBOUNCE_CYCLES = lts_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [11:0] digitalInput,
  lts_sync_if.sync         link
);
  localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);

  logic [11:0]   inMeta;
  logic [11:0]   inSync;
  logic [3:0]    lastSource;
  logic          filtered;
  logic [DW-1:0] count;

  //==============================================================
  // Selection
  wire srcValid   = (link.source != 4'h0) && (link.source <= lts_pkg::NUM_INPUTS);
  wire [3:0] idx  = link.source - 4'h1;
  wire selLevel   = srcValid ? inSync[idx] : 1'b0;
  wire srcChanged = link.source != lastSource;
  wire differ     = selLevel != filtered;
  wire settled    = differ && (count == DW'(DEBOUNCE_CYCLES - 1));

  //==============================================================
  // Synchroniser and filter
  always_ff @(posedge sys_clk)
  begin
    inMeta <= digitalInput;
    inSync <= inMeta;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lastSource       <= 4'h0;
      filtered         <= 1'b0;
      count            <= '0;
      link.minutePulse <= 1'b0;
    end
    else
    begin
      lastSource       <= link.source;
      link.minutePulse <= settled && selLevel && !srcChanged;
      if (srcChanged)
      begin
        filtered <= selLevel;
        count    <= '0;
      end
      else if (settled)
      begin
        filtered <= selLevel;
        count    <= '0;
      end
      else if (differ)
        count <= count + DW'(1);
      else
        count <= '0;
    end
  end

  //==============================================================
  // Checks
  a_none_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    !srcValid |=> !link.minutePulse)
    else $error("pulse with no source selected");
  a_pulse_debounced: assert property (@(posedge sys_clk) disable iff (rst)
    link.minutePulse |-> filtered && !$past(filtered) && ($past(count) == DW'(DEBOUNCE_CYCLES - 1)))
    else $error("pulse before debounce time");
  a_single_edge: assert property (@(posedge sys_clk) disable iff (rst)
    link.minutePulse |=> !link.minutePulse)
    else $error("pulse longer than one cycle");
endmodule
`default_nettype wire

// ### rtl/lts_local_time.sv
// Calendar clock with seasonal hour shift and minute pulse alignment
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module lts_local_time #(
  parameter int unsigned TICK_CYCLES     = lts_pkg::TICK_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = lts_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output var  logic [31:0] wbDatO,
  output var  logic        wbAck,
  input  wire logic [11:0] digitalInput,
  output var  logic        shiftActive,
  output var  logic        minuteAligned
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  //==============================================================
  // Functions
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = dat[8*i +: 8];
    return r;
  endfunction

  function automatic logic [4:0] daysIn(input logic [3:0] m, input logic [6:0] y);
    case (m)
      4'h2: return (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: return 5'h1e;
      default: return 5'h1f;
    endcase
  endfunction

  function automatic logic [31:0] ptWord(input lts_pkg::lts_point_s p);
    logic [31:0] w;
    w = 32'h0;
    w[lts_pkg::PT_MON  +: 4] = p.month;
    w[lts_pkg::PT_WEEK +: 3] = p.week;
    w[lts_pkg::PT_WDAY +: 3] = p.wday;
    w[lts_pkg::PT_HOUR +: 3] = p.hour;
    return w;
  endfunction

  // Out-of-range fields keep their old value
  function automatic lts_pkg::lts_point_s ptUpd(input lts_pkg::lts_point_s o,
                                                input logic [31:0] w);
    lts_pkg::lts_point_s p;
    logic [3:0] m;
    logic [2:0] k;
    logic [2:0] d;
    logic [2:0] h;
    p = o;
    m = w[lts_pkg::PT_MON  +: 4];
    k = w[lts_pkg::PT_WEEK +: 3];
    d = w[lts_pkg::PT_WDAY +: 3];
    h = w[lts_pkg::PT_HOUR +: 3];
    if (m >= 4'h1 && m <= 4'hc)
      p.month = m;
    if (k <= 3'h4)
      p.week = k;
    if (d != 3'h0)
      p.wday = d;
    if (h >= lts_pkg::HOUR_MIN && h <= lts_pkg::HOUR_MAX)
      p.hour = h;
    return p;
  endfunction

  function automatic logic dateHit(input lts_pkg::lts_point_s p, input logic [3:0] m,
                                   input logic [4:0] md, input logic [2:0] wd,
                                   input logic [4:0] dim);
    logic [4:0] wk;
    logic       wkOk;
    wk   = (md - 5'h01) / 5'h07 + 5'h01;
    wkOk = (p.week == lts_pkg::WEEK_LAST) ? ({1'b0, md} + 6'h07 > {1'b0, dim}) :
           (wk == {2'h0, p.week});
    return (p.month == m) && (p.wday == wd) && wkOk;
  endfunction

  //==============================================================
  // State
  lts_pkg::lts_point_s startPt;
  lts_pkg::lts_point_s endPt;
  logic          shiftEnable;
  logic [3:0]    syncSource;
  logic [7:0]    country;
  logic [5:0]    sec;
  logic [5:0]    min;
  logic [4:0]    hour;
  logic [4:0]    mday;
  logic [3:0]    month;
  logic [2:0]    wday;
  logic [6:0]    year;
  logic          lastRoundUp;
  logic [TW-1:0] tickCount;

  lts_sync_if syncLink ();

  lts_minute_sync #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) uSync (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .digitalInput (digitalInput),
    .link         (syncLink.sync)
  );
  assign syncLink.source = syncSource;

  //==============================================================
  // Bus decode
  wire req      = wbCyc && wbStb;
  wire wrFire   = req && wbAck && wbWe;
  wire wrCtrl   = wrFire && (wbAdr == lts_pkg::ADDR_CTRL);
  wire wrStart  = wrFire && (wbAdr == lts_pkg::ADDR_START);
  wire wrEnd    = wrFire && (wbAdr == lts_pkg::ADDR_END);
  wire wrTime   = wrFire && (wbAdr == lts_pkg::ADDR_TIME);
  wire wrDate   = wrFire && (wbAdr == lts_pkg::ADDR_DATE);

  wire [31:0] ctrlWord = {16'h0, country, syncSource, 3'h0, shiftEnable};
  wire [31:0] timeWord = {11'h0, hour, 2'h0, min, 2'h0, sec};
  wire [31:0] dateWord = {1'h0, year, 5'h0, wday, 4'h0, month, 3'h0, mday};
  wire [31:0] statWord = {30'h0, lastRoundUp, shiftActive};
  wire [31:0] readWord =
      (wbAdr == lts_pkg::ADDR_CTRL)   ? ctrlWord :
      (wbAdr == lts_pkg::ADDR_START)  ? ptWord(startPt) :
      (wbAdr == lts_pkg::ADDR_END)    ? ptWord(endPt) :
      (wbAdr == lts_pkg::ADDR_TIME)   ? timeWord :
      (wbAdr == lts_pkg::ADDR_DATE)   ? dateWord :
      (wbAdr == lts_pkg::ADDR_STATUS) ? statWord : 32'h0;

  wire [31:0] ctrlNew = merge(ctrlWord, wbDatI, wbSel);
  wire [31:0] timeNew = merge(timeWord, wbDatI, wbSel);
  wire [31:0] dateNew = merge(dateWord, wbDatI, wbSel);
  wire [3:0]  srcNew  = ctrlNew[lts_pkg::CTRL_SRC +: 4];
  wire [5:0]  wSec    = timeNew[lts_pkg::TM_SEC  +: 6];
  wire [5:0]  wMin    = timeNew[lts_pkg::TM_MIN  +: 6];
  wire [4:0]  wHour   = timeNew[lts_pkg::TM_HOUR +: 5];
  wire [4:0]  wMday   = dateNew[lts_pkg::DT_MDAY +: 5];
  wire [3:0]  wMon    = dateNew[lts_pkg::DT_MON  +: 4];
  wire [2:0]  wWday   = dateNew[lts_pkg::DT_WDAY +: 3];
  wire [6:0]  wYear   = dateNew[lts_pkg::DT_YEAR +: 7];

  //==============================================================
  // Calendar advance
  wire tick     = tickCount == TW'(TICK_CYCLES - 1);
  wire align    = syncLink.minutePulse;
  wire roundUp  = align && (sec >= 6'h1e);
  wire secWrap  = (tick && sec == 6'h3b) || roundUp;
  wire minWrap  = secWrap && (min == 6'h3b);
  wire dayRoll  = minWrap && (hour == 5'h17);
  wire [4:0] dim      = daysIn(month, year);
  wire [4:0] plainHr  = (hour == 5'h17) ? 5'h00 : hour + 5'h01;
  wire [4:0] startHr  = {2'h0, startPt.hour};
  wire [4:0] endHr    = {2'h0, endPt.hour};
  wire startDate = dateHit(startPt, month, mday, wday, dim);
  wire endDate   = dateHit(endPt, month, mday, wday, dim);
  wire fwdHit  = minWrap && !dayRoll && shiftEnable && !shiftActive
                 && startDate && (plainHr == startHr);
  wire backHit = minWrap && !dayRoll && shiftEnable && shiftActive
                 && endDate && (plainHr == endHr);

  wire [5:0] advSec  = align ? 6'h00 : !tick ? sec :
                       (sec == 6'h3b) ? 6'h00 : sec + 6'h01;
  wire [5:0] advMin  = !secWrap ? min : (min == 6'h3b) ? 6'h00 : min + 6'h01;
  wire [4:0] advHour = fwdHit ? startHr + 5'h01 :
                       backHit ? endHr - 5'h01 :
                       minWrap ? plainHr : hour;
  wire monEnd  = dayRoll && (mday == dim);
  wire yrEnd   = monEnd && (month == 4'hc);
  wire [4:0] advMday = !dayRoll ? mday : monEnd ? 5'h01 : mday + 5'h01;
  wire [3:0] advMon  = !monEnd ? month : yrEnd ? 4'h1 : month + 4'h1;
  wire [6:0] advYear = !yrEnd ? year : (year == 7'h63) ? 7'h00 : year + 7'h01;
  wire [2:0] advWday = !dayRoll ? wday : (wday == 3'h7) ? 3'h1 : wday + 3'h1;

  wire [5:0] next_sec   = (wrTime && wSec < 6'h3c) ? wSec : advSec;
  wire [5:0] next_min   = (wrTime && wMin < 6'h3c) ? wMin : advMin;
  wire [4:0] next_hour  = (wrTime && wHour < 5'h18) ? wHour : advHour;
  wire [4:0] next_mday  = (wrDate && wMday != 5'h00) ? wMday : advMday;
  wire [3:0] next_month = (wrDate && wMon != 4'h0 && wMon <= 4'hc) ? wMon : advMon;
  wire [2:0] next_wday  = (wrDate && wWday != 3'h0) ? wWday : advWday;
  wire [6:0] next_year  = (wrDate && wYear <= 7'h63) ? wYear : advYear;
  wire next_shiftEnable = wrCtrl ? ctrlNew[lts_pkg::CTRL_EN] : shiftEnable;
  wire next_shiftActive = !next_shiftEnable ? 1'b0 :
                          fwdHit ? 1'b1 : backHit ? 1'b0 : shiftActive;

  //==============================================================
  // Registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wbAck  <= 1'b0;
      wbDatO <= 32'h0;
    end
    else
    begin
      wbAck <= req && !wbAck;
      if (req && !wbAck)
        wbDatO <= readWord;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      shiftEnable <= 1'b0;
      syncSource  <= lts_pkg::RST_SRC;
      country     <= lts_pkg::RST_CTRY;
      startPt     <= lts_pkg::RST_POINT;
      endPt       <= lts_pkg::RST_POINT;
    end
    else
    begin
      shiftEnable <= next_shiftEnable;
      if (wrCtrl)
        country <= ctrlNew[lts_pkg::CTRL_CTRY +: 8];
      if (wrCtrl && srcNew <= lts_pkg::NUM_INPUTS)
        syncSource <= srcNew;
      if (wrStart)
        startPt <= ptUpd(startPt, merge(ptWord(startPt), wbDatI, wbSel));
      if (wrEnd)
        endPt <= ptUpd(endPt, merge(ptWord(endPt), wbDatI, wbSel));
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tickCount     <= '0;
      sec           <= 6'h00;
      min           <= 6'h00;
      hour          <= 5'h00;
      mday          <= lts_pkg::RST_MDAY;
      month         <= lts_pkg::RST_MON;
      wday          <= lts_pkg::RST_WDAY;
      year          <= lts_pkg::RST_YEAR;
      shiftActive   <= 1'b0;
      lastRoundUp   <= 1'b0;
      minuteAligned <= 1'b0;
    end
    else
    begin
      tickCount     <= (tick || align) ? '0 : tickCount + TW'(1);
      sec           <= next_sec;
      min           <= next_min;
      hour          <= next_hour;
      mday          <= next_mday;
      month         <= next_month;
      wday          <= next_wday;
      year          <= next_year;
      shiftActive   <= next_shiftActive;
      minuteAligned <= align;
      if (align)
        lastRoundUp <= roundUp;
    end
  end

  //==============================================================
  // Checks
  a_off_no_shift: assert property (@(posedge sys_clk) disable iff (rst)
    !shiftEnable |-> !fwdHit && !backHit ##1 !shiftActive)
    else $error("hour shift while disabled");
  a_fwd_hour: assert property (@(posedge sys_clk) disable iff (rst || wrTime)
    fwdHit |=> hour == $past(startHr) + 5'h01 && shiftActive)
    else $error("forward shift wrong");
  a_back_hour: assert property (@(posedge sys_clk) disable iff (rst || wrTime)
    backHit |=> hour == $past(endHr) - 5'h01 && !shiftActive)
    else $error("backward shift wrong");
  a_start_fields: assert property (@(posedge sys_clk) disable iff (rst)
    startPt.month >= 4'h1 && startPt.month <= 4'hc && startPt.week <= 3'h4
    && startPt.wday != 3'h0)
    else $error("start date out of range");
  a_start_hour: assert property (@(posedge sys_clk) disable iff (rst)
    startPt.hour >= lts_pkg::HOUR_MIN && startPt.hour <= lts_pkg::HOUR_MAX)
    else $error("start hour out of range");
  a_end_hour: assert property (@(posedge sys_clk) disable iff (rst)
    endPt.hour >= lts_pkg::HOUR_MIN && endPt.hour <= lts_pkg::HOUR_MAX
    && endPt.month >= 4'h1 && endPt.month <= 4'hc)
    else $error("end point out of range");
  a_source_range: assert property (@(posedge sys_clk) disable iff (rst)
    syncSource <= lts_pkg::NUM_INPUTS)
    else $error("sync source out of range");
  a_align_round: assert property (@(posedge sys_clk) disable iff (rst || wrTime)
    align && !minWrap |=> sec == 6'h00 && minuteAligned
    && min == (($past(sec) >= 6'h1e) ? $past(min) + 6'h01 : $past(min)))
    else $error("minute alignment wrong");
  a_ack_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    req && !wbAck |=> wbAck ##1 !wbAck)
    else $error("bus ack timing wrong");
endmodule
`default_nettype wire

// ### verification/lts_relay_model.sv
// Minute pulse contact model driving one of the twelve digital inputs
`timescale 1ns/100ps
`default_nettype none
module lts_relay_model (
  input  wire logic        sys_clk,
  input  wire logic        fire,
  input  wire logic [3:0]  chan,
  input  wire logic [7:0]  holdCycles,
  output var  logic [11:0] digitalInput
);
  //==============================================================
  // Contact bounce, stable closure, then open
  initial digitalInput = 12'h000;
  always @(posedge fire)
  begin
    repeat (3)
    begin
      @(posedge sys_clk);
      digitalInput[chan - 4'h1] <= ~digitalInput[chan - 4'h1];
    end
    @(posedge sys_clk);
    if (holdCycles != 8'h00)
    begin
      digitalInput[chan - 4'h1] <= 1'b1;
      repeat (holdCycles) @(posedge sys_clk);
    end
    digitalInput[chan - 4'h1] <= 1'b0;
  end
endmodule
`default_nettype wire

// ### verification/lts_local_time_tb.sv
// Self-checking bench for the local time shift and minute alignment block
`timescale 1ns/100ps
`default_nettype none
module lts_local_time_tb;
  localparam int unsigned DEB   = 4;
  localparam int unsigned LIMIT = 20000;
  logic        sys_clk, rst, wbCyc, wbStb, wbWe, fire, got;
  logic        shiftActive, minuteAligned, wbAck;
  logic [7:0]  wbAdr, holdCycles;
  logic [3:0]  wbSel, chan, ch;
  logic [31:0] wbDatI, wbDatO, rd, tm, seed;
  logic [11:0] digitalInput;
  logic [5:0]  m, s;
  int          bad_count, n_compared;
  int          cycles = 0;

  //==============================================================
  // Design and contact model
  lts_local_time #(.TICK_CYCLES(20), .DEBOUNCE_CYCLES(DEB)) uut (
    .sys_clk(sys_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .digitalInput(digitalInput), .shiftActive(shiftActive),
    .minuteAligned(minuteAligned));
  lts_relay_model relay (.sys_clk(sys_clk), .fire(fire), .chan(chan),
    .holdCycles(holdCycles), .digitalInput(digitalInput));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  //==============================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] exp_time(input logic [5:0] mi, input logic [5:0] se);
    exp_time = {11'h0, 5'h0a, 2'h0, (se >= 6'd30) ? mi + 6'h1 : mi, 8'h00};
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel, output logic [31:0] q);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatI <= dat;
    wbSel  <= sel;
    do
    begin
      @(posedge sys_clk);
    end while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, 4'hf, rd);
  endtask
  task automatic rdc(input string what, input logic [7:0] adr, input logic [31:0] msk,
                     input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, 4'hf, rd);
    check(what, exp, rd & msk);
  endtask
  task automatic wait_shift(input logic v);
    int n;
    n = 0;
    while (shiftActive !== v && n < 80)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (shiftActive !== v)
    begin
      bad_count++;
      $display("[FAIL] shift wait expected %b seen %b", v, shiftActive);
    end
  endtask
  task automatic pulse(input logic [3:0] c, input logic [7:0] hold);
    int n;
    n = 0;
    chan       <= c;
    holdCycles <= hold;
    fire       <= 1'b1;
    got = 1'b0;
    while (got !== 1'b1 && n < DEB + 30)
    begin
      @(posedge sys_clk);
      n++;
      got = minuteAligned;
    end
    wb(1'b0, lts_pkg::ADDR_TIME, 32'h0, 4'hf, tm);
    fire <= 1'b0;
    repeat (hold + 12) @(posedge sys_clk);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  //==============================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    {wbCyc, wbStb, wbWe, fire} = 4'h0;
    {wbAdr, holdCycles, wbSel, chan} = 24'h0;
    wbDatI = 32'h0;
    seed = 32'd94;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc("ctrl", lts_pkg::ADDR_CTRL, 32'hffffffff, 32'h0);
    rdc("start", lts_pkg::ADDR_START, 32'h777f, 32'h2703);
    rdc("end", lts_pkg::ADDR_END, 32'h777f, 32'h2703);
    rdc("status", lts_pkg::ADDR_STATUS, 32'h3, 32'h0);
    rdc("unmapped", 8'h20, 32'hffffffff, 32'h0);
    wr(lts_pkg::ADDR_START, 32'h0000705d);
    rdc("start bad", lts_pkg::ADDR_START, 32'h777f, 32'h2703);
    wr(lts_pkg::ADDR_END, 32'h0000015c);
    rdc("end mixed", lts_pkg::ADDR_END, 32'h777f, 32'h210c);
    wb(1'b1, lts_pkg::ADDR_END, 32'h00006003, 4'h1, rd);
    rdc("end byte", lts_pkg::ADDR_END, 32'h777f, 32'h2103);
    wr(lts_pkg::ADDR_CTRL, 32'h000000d0);
    rdc("src bad", lts_pkg::ADDR_CTRL, 32'hff, 32'h0);
    // Last Sunday of March, shift off then on
    wr(lts_pkg::ADDR_END, 32'h00003703);
    wr(lts_pkg::ADDR_DATE, 32'h0107031d);
    wr(lts_pkg::ADDR_TIME, 32'h00013b3b);
    repeat (30) @(posedge sys_clk);
    rdc("time off", lts_pkg::ADDR_TIME, 32'h1f3f00, 32'h00020000);
    check("active off", 32'h0, {31'h0, shiftActive});
    wr(lts_pkg::ADDR_CTRL, 32'h00000001);
    wr(lts_pkg::ADDR_TIME, 32'h00013b3b);
    wait_shift(1'b1);
    rdc("time fwd", lts_pkg::ADDR_TIME, 32'h1f3f00, 32'h00030000);
    rdc("status on", lts_pkg::ADDR_STATUS, 32'h1, 32'h1);
    wr(lts_pkg::ADDR_TIME, 32'h00023b3b);
    wait_shift(1'b0);
    rdc("time back", lts_pkg::ADDR_TIME, 32'h1f3f00, 32'h00020000);
    // First Monday of April, start hour one
    wr(lts_pkg::ADDR_START, 32'h00001114);
    wr(lts_pkg::ADDR_DATE, 32'h01010403);
    wr(lts_pkg::ADDR_TIME, 32'h00003b3b);
    wait_shift(1'b1);
    rdc("time week1", lts_pkg::ADDR_TIME, 32'h1f3f00, 32'h00020000);
    // Minute alignment on random inputs and seconds
    for (int i = 0; i < 8; i++)
    begin
      ch = 4'(xs() % 12 + 1);
      m  = 6'(xs() % 59);
      s  = (i % 2 == 1) ? 6'(30 + xs() % 28) : 6'(xs() % 29);
      wr(lts_pkg::ADDR_CTRL, {24'h0, ch, 4'h0});
      wr(lts_pkg::ADDR_TIME, {11'h0, 5'h0a, 2'h0, m, 2'h0, s});
      pulse(ch, 8'd40);
      check("aligned", 32'h1, {31'h0, got});
      check("time aligned", exp_time(m, s), tm);
      rdc("round up", lts_pkg::ADDR_STATUS, 32'h2, {30'h0, s >= 6'd30, 1'b0});
    end
    wr(lts_pkg::ADDR_CTRL, 32'h00000050);
    pulse(4'h6, 8'd40);
    check("other input", 32'h0, {31'h0, got});
    wr(lts_pkg::ADDR_CTRL, 32'h00000000);
    pulse(4'h1, 8'd40);
    check("no source", 32'h0, {31'h0, got});
    wr(lts_pkg::ADDR_CTRL, 32'h00000020);
    pulse(4'h2, 8'd0);
    check("glitch", 32'h0, {31'h0, got});
    report_and_stop();
  end
endmodule
`default_nettype wire
